// ---- src/irq_event_latch.sv ----
`timescale 1ns/1ps

// Sticky flag bank: hardware set wins over software clear.
module irq_event_latch #(
    parameter int WIDTH = 6
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_set,
    input  wire logic [WIDTH-1:0] i_clr,
    output logic      [WIDTH-1:0] o_flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } latch_state_t;

    latch_state_t state_ff;
    latch_state_t nxt_state;

    always_comb begin
        nxt_state       = state_ff;
        nxt_state.flags = (state_ff.flags & ~i_clr) | i_set;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_flags = state_ff.flags;

endmodule

// ---- src/irq_regs_pkg.sv ----
package irq_regs_pkg;

    // ========================================================
    // Register map (word addresses on the plain register port)
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  ADDR_CELL_EN    = 4'h0;
    localparam logic [3:0]  ADDR_FLAGS      = 4'h1;
    localparam logic [3:0]  ADDR_CORE_CTL   = 4'h2;
    localparam logic [3:0]  ADDR_EVT_STAT   = 4'h3;
    localparam logic [3:0]  ADDR_EVT_CLR    = 4'h4;
    localparam logic [3:0]  ADDR_EVT_EN     = 4'h5;

    // ========================================================
    // Field positions
    localparam int          CELL1_EN_BIT    = 0;
    localparam int          CELL2_EN_BIT    = 1;
    localparam int          T1_OVF_BIT      = 0;
    localparam int          T2_MATCH_BIT    = 1;
    localparam int          ADC_BIT         = 6;
    localparam int          T1_GATE_BIT     = 7;
    localparam int          GLOBAL_GATE_BIT = 7;
    localparam int          PERIPH_GATE_BIT = 6;

    // Implemented-bit masks; other bits ignore writes, read 0
    localparam logic [7:0]  CELL_EN_MASK    = 8'h03;
    localparam logic [7:0]  FLAGS_MASK      = 8'hC3;
    localparam logic [7:0]  CORE_CTL_MASK   = 8'hC0;
    localparam logic [7:0]  RESET_VAL       = 8'h00;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic       t1_gate;
        logic       adc;
        logic       t2_match;
        logic       t1_ovf;
        logic       cell2;
        logic       cell1;
    } periph_evt_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

endpackage

// ---- src/periph_irq_regs.sv ----
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

module periph_irq_regs (
    input  wire logic                      i_clock,
    input  wire logic                      i_rst,
    input  wire logic [3:0]                i_addr,
    input  wire logic [7:0]                i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    input  wire irq_regs_pkg::periph_evt_t i_evt,
    output logic      [7:0]                o_rdata,
    output logic                           o_periph_irq,
    output logic                           o_core_irq,
    output logic                           o_irq
);

    // ========================================================
    // State
    typedef struct packed {
        logic [7:0] cell_en;
        logic [7:0] core_ctl;
        logic [5:0] evt_en;
        logic [7:0] rdata;
        logic       periph_irq;
        logic       core_irq;
        logic       irq;
    } regs_state_t;

    regs_state_t state_ff;
    regs_state_t nxt_state;

    logic [7:0] flags;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic [5:0] evt_flags;
    logic [5:0] evt_clr;
    logic [5:0] evt_vec;

    function automatic logic hit(input logic [3:0] a,
                                 input logic [3:0] want);
        hit = (a == want);
    endfunction

    // ========================================================
    // Peripheral flags
    always_comb begin
        flag_set = '0;
        flag_set[irq_regs_pkg::T1_GATE_BIT]  = i_evt.t1_gate;
        flag_set[irq_regs_pkg::ADC_BIT]      = i_evt.adc;
        flag_set[irq_regs_pkg::T2_MATCH_BIT] = i_evt.t2_match;
        flag_set[irq_regs_pkg::T1_OVF_BIT]   = i_evt.t1_ovf;
        // Writing 0 clears; writing 1 to a clear flag sets it (R/W)
        flag_clr = '0;
        if (i_wr && hit(i_addr, irq_regs_pkg::ADDR_FLAGS)) begin
            flag_clr = ~i_wdata & irq_regs_pkg::FLAGS_MASK;
            flag_set = flag_set
                     | (i_wdata & irq_regs_pkg::FLAGS_MASK);
        end
    end

    irq_event_latch #(
        .WIDTH (8)
    ) u_flags (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_set   (flag_set & irq_regs_pkg::FLAGS_MASK),
        .i_clr   (flag_clr),
        .o_flags (flags)
    );

    // ========================================================
    // Event status (sticky, write-one-to-clear register)
    assign evt_vec = {i_evt.t1_gate, i_evt.adc, i_evt.t2_match,
                      i_evt.t1_ovf, i_evt.cell2, i_evt.cell1};
    assign evt_clr = (i_wr && hit(i_addr, irq_regs_pkg::ADDR_EVT_CLR))
                   ? i_wdata[5:0] : 6'h00;

    irq_event_latch #(
        .WIDTH (6)
    ) u_evt (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_set   (evt_vec),
        .i_clr   (evt_clr),
        .o_flags (evt_flags)
    );

    // ========================================================
    // Registers and interrupt lines
    always_comb begin
        logic any_periph;
        logic any_evt;
        any_periph = 1'b0;
        any_evt    = 1'b0;
        nxt_state  = state_ff;
        if (i_wr) begin
            unique case (1'b1)
                hit(i_addr, irq_regs_pkg::ADDR_CELL_EN): begin
                    nxt_state.cell_en = i_wdata
                        & irq_regs_pkg::CELL_EN_MASK;
                end
                hit(i_addr, irq_regs_pkg::ADDR_CORE_CTL): begin
                    nxt_state.core_ctl = i_wdata
                        & irq_regs_pkg::CORE_CTL_MASK;
                end
                hit(i_addr, irq_regs_pkg::ADDR_EVT_EN): begin
                    nxt_state.evt_en = i_wdata[5:0];
                end
                default: begin
                end
            endcase
        end
        nxt_state.rdata = irq_regs_pkg::RESET_VAL;
        if (i_rd) begin
            unique case (1'b1)
                hit(i_addr, irq_regs_pkg::ADDR_CELL_EN):
                    nxt_state.rdata = state_ff.cell_en;
                hit(i_addr, irq_regs_pkg::ADDR_FLAGS):
                    nxt_state.rdata = flags;
                hit(i_addr, irq_regs_pkg::ADDR_CORE_CTL):
                    nxt_state.rdata = state_ff.core_ctl;
                hit(i_addr, irq_regs_pkg::ADDR_EVT_STAT):
                    nxt_state.rdata = {2'h0, evt_flags};
                hit(i_addr, irq_regs_pkg::ADDR_EVT_EN):
                    nxt_state.rdata = {2'h0, state_ff.evt_en};
                default:
                    nxt_state.rdata = irq_regs_pkg::RESET_VAL;
            endcase
        end
        // Cell flags live elsewhere; their events arrive as pulses
        any_periph =
            (i_evt.cell1 && state_ff.cell_en[irq_regs_pkg::CELL1_EN_BIT])
         || (i_evt.cell2 && state_ff.cell_en[irq_regs_pkg::CELL2_EN_BIT]);
        nxt_state.periph_irq = any_periph
            && state_ff.core_ctl[irq_regs_pkg::PERIPH_GATE_BIT];
        nxt_state.core_irq = nxt_state.periph_irq
            && state_ff.core_ctl[irq_regs_pkg::GLOBAL_GATE_BIT];
        any_evt = |(evt_flags & state_ff.evt_en);
        nxt_state.irq = any_evt;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_rdata      = state_ff.rdata;
    assign o_periph_irq = state_ff.periph_irq;
    assign o_core_irq   = state_ff.core_irq;
    assign o_irq        = state_ff.irq;

    // ========================================================
    // Checks
    flag_sticky_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        $past(i_evt.adc) |-> flags[irq_regs_pkg::ADC_BIT])
        else $error("converter flag missed its event");
    set_wins_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_evt.t1_ovf && i_wr && i_addr == irq_regs_pkg::ADDR_FLAGS
         && !i_wdata[irq_regs_pkg::T1_OVF_BIT])
        |=> flags[irq_regs_pkg::T1_OVF_BIT])
        else $error("clear beat a same-cycle event");
    flag_clear_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_wr && i_addr == irq_regs_pkg::ADDR_FLAGS && i_wdata == 8'h00
         && i_evt == '0) |=> flags == 8'h00)
        else $error("flag write of zero did not clear");
    flag_hold_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (flags[irq_regs_pkg::T1_GATE_BIT]
         && !(i_wr && i_addr == irq_regs_pkg::ADDR_FLAGS))
        |=> flags[irq_regs_pkg::T1_GATE_BIT])
        else $error("timer1 gate flag dropped by itself");
    unimpl_zero_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (flags & ~irq_regs_pkg::FLAGS_MASK) == 8'h00)
        else $error("unimplemented flag bit set");
    enable_read_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_wr && i_addr == irq_regs_pkg::ADDR_CELL_EN) ##1
        (i_rd && i_addr == irq_regs_pkg::ADDR_CELL_EN && !i_wr)
        |=> o_rdata == ($past(i_wdata, 2) & irq_regs_pkg::CELL_EN_MASK))
        else $error("enable read-back wrong");
    gate_block_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !state_ff.core_ctl[irq_regs_pkg::PERIPH_GATE_BIT]
        |=> !o_periph_irq)
        else $error("peripheral irq passed a closed gate");
    flag_bits_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        $past(i_evt.t2_match) |-> flags[irq_regs_pkg::T2_MATCH_BIT])
        else $error("timer2 match flag missed its event");
    unmapped_read_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_rd && i_addr > irq_regs_pkg::ADDR_EVT_EN) |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    irq_level_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (|(evt_flags & state_ff.evt_en)) |=> o_irq)
        else $error("interrupt line not raised");
    gate_flag_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        $past(i_evt.t1_gate) |-> flags[irq_regs_pkg::T1_GATE_BIT])
        else $error("timer1 gate flag missed its event");
    adc_clear_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_wr && i_addr == irq_regs_pkg::ADDR_FLAGS
         && !i_wdata[irq_regs_pkg::ADC_BIT] && !i_evt.adc)
        |=> !flags[irq_regs_pkg::ADC_BIT])
        else $error("converter flag not cleared by write");
    ovf_flag_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        $past(i_evt.t1_ovf) |-> flags[irq_regs_pkg::T1_OVF_BIT])
        else $error("timer1 overflow flag missed its event");
    enable_unimpl_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (state_ff.cell_en & ~irq_regs_pkg::CELL_EN_MASK) == 8'h00)
        else $error("unimplemented enable bit set");
    core_gate_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        o_core_irq |-> o_periph_irq)
        else $error("core irq without peripheral irq");
    rdata_idle_a: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !i_rd |=> o_rdata == irq_regs_pkg::RESET_VAL)
        else $error("read data outside its cycle");

    cell_irq_c: cover property (@(posedge i_clock) o_periph_irq);
    core_irq_c: cover property (@(posedge i_clock) o_core_irq);
    race_c: cover property (@(posedge i_clock) i_evt.adc && i_wr
        && i_addr == irq_regs_pkg::ADDR_FLAGS);
    sum_irq_c: cover property (@(posedge i_clock) o_irq);

endmodule

// ---- verification/periph_event_source.sv ----
`timescale 1ns/1ps

// ========================================================
// Peripheral event sources: one-cycle pulses
module periph_event_source (
    input  wire logic                 i_clock,
    output irq_regs_pkg::periph_evt_t o_evt
);
    initial o_evt = '0;

    // Pulse starts after an edge, is taken at the next one
    task automatic fire(input irq_regs_pkg::periph_evt_t v);
        o_evt <= v;
        @(posedge i_clock);
        o_evt <= '0;
    endtask
endmodule

// ---- verification/periph_irq_regs_tb_top.sv ----
`timescale 1ns/1ps

module periph_irq_regs_tb_top;
    logic                      i_clock;
    logic                      i_rst;
    logic [3:0]                i_addr;
    logic [7:0]                i_wdata;
    logic                      i_wr;
    logic                      i_rd;
    irq_regs_pkg::periph_evt_t i_evt;
    logic [7:0]                o_rdata;
    logic                      o_periph_irq;
    logic                      o_core_irq;
    logic                      o_irq;
    int                        n_errors;
    int                        comparisons;
    logic [5:0]                evts [4] = '{6'h20, 6'h10, 6'h08, 6'h04};
    logic [7:0]                flg  [4] = '{8'h80, 8'h40, 8'h02, 8'h01};
    logic [7:0]                ctl  [4] = '{8'h3F, 8'hBF, 8'h7F, 8'hFF};
    logic [3:0]                pe       = 4'b1100;
    logic [3:0]                ce       = 4'b1000;

    periph_irq_regs u_periph_irq_regs (
        .i_clock      (i_clock),
        .i_rst        (i_rst),
        .i_addr       (i_addr),
        .i_wdata      (i_wdata),
        .i_wr         (i_wr),
        .i_rd         (i_rd),
        .i_evt        (i_evt),
        .o_rdata      (o_rdata),
        .o_periph_irq (o_periph_irq),
        .o_core_irq   (o_core_irq),
        .o_irq        (o_irq)
    );

    periph_event_source u_periph_event_source (
        .i_clock (i_clock),
        .o_evt   (i_evt)
    );

    initial i_clock = 1'b0;
    always #2.5 i_clock = ~i_clock;

    // ========================================================
    // Bus and checking tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // Gap cycle after release keeps strobes single-driven
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clock);
        i_wr    <= 1'b0;
        @(posedge i_clock);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        #1;
        check(o_rdata, exp);
        @(posedge i_clock);
    endtask

    // Write then read back with no idle cycle between the strobes
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d,
                         input logic [7:0] exp);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clock);
        i_wr    <= 1'b0;
        i_rd    <= 1'b1;
        @(posedge i_clock);
        i_rd    <= 1'b0;
        #1;
        check(o_rdata, exp);
        @(posedge i_clock);
    endtask

    task automatic pulse(input logic [5:0] v, input logic ep,
                         input logic ec);
        u_periph_event_source.fire(v);
        #1;
        check({7'h00, o_periph_irq}, {7'h00, ep});
        check({7'h00, o_core_irq}, {7'h00, ec});
        @(posedge i_clock);
    endtask

    // o_irq lags the enable or clear write by one cycle
    task automatic irq_chk(input logic e);
        @(posedge i_clock);
        #1;
        check({7'h00, o_irq}, {7'h00, e});
        @(posedge i_clock);
    endtask

    task automatic final_report;
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ========================================================
    // Main sequence
    initial begin
        i_rst   = 1'b1;
        i_addr  = '0;
        i_wdata = '0;
        i_wr    = 1'b0;
        i_rd    = 1'b0;
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        rd(irq_regs_pkg::ADDR_CELL_EN, 8'h00);
        rd(irq_regs_pkg::ADDR_FLAGS, 8'h00);
        wr(irq_regs_pkg::ADDR_CELL_EN, 8'hFF);
        rd(irq_regs_pkg::ADDR_CELL_EN, 8'h03);
        wr_rd(irq_regs_pkg::ADDR_CELL_EN, 8'hF3, 8'h03);
        wr(irq_regs_pkg::ADDR_FLAGS, 8'hFF);
        rd(irq_regs_pkg::ADDR_FLAGS, 8'hC3);
        wr(irq_regs_pkg::ADDR_FLAGS, 8'h00);
        rd(irq_regs_pkg::ADDR_FLAGS, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        // Gates are off, so flags must latch on their own
        for (int i = 0; i < 4; i++) begin
            pulse(evts[i], 1'b0, 1'b0);
            rd(irq_regs_pkg::ADDR_FLAGS, flg[i]);
            wr(irq_regs_pkg::ADDR_FLAGS, 8'h00);
        end
        fork
            u_periph_event_source.fire(6'h14);
            wr(irq_regs_pkg::ADDR_FLAGS, 8'h00);
        join
        rd(irq_regs_pkg::ADDR_FLAGS, 8'h41);
        wr(irq_regs_pkg::ADDR_FLAGS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(irq_regs_pkg::ADDR_CORE_CTL, ctl[i]);
            rd(irq_regs_pkg::ADDR_CORE_CTL, ctl[i] & 8'hC0);
            pulse(6'h01, pe[i], ce[i]);
            pulse(6'h02, pe[i], ce[i]);
        end
        wr(irq_regs_pkg::ADDR_CELL_EN, 8'h02);
        pulse(6'h01, 1'b0, 1'b0);
        // Status, mask and clear of the summary interrupt
        wr(irq_regs_pkg::ADDR_EVT_EN, 8'h00);
        pulse(6'h3F, 1'b1, 1'b1);
        rd(irq_regs_pkg::ADDR_EVT_STAT, 8'h3F);
        irq_chk(1'b0);
        wr(irq_regs_pkg::ADDR_EVT_EN, 8'h01);
        irq_chk(1'b1);
        wr(irq_regs_pkg::ADDR_EVT_CLR, 8'h01);
        irq_chk(1'b0);
        wr(irq_regs_pkg::ADDR_EVT_STAT, 8'h00);
        rd(irq_regs_pkg::ADDR_EVT_STAT, 8'h3E);
        rd(irq_regs_pkg::ADDR_FLAGS, 8'hC3);
        final_report;
    end

    // Hang guard
    initial begin
        repeat (3000) @(posedge i_clock);
        n_errors++;
        final_report;
    end
endmodule
